// file: bench/ocf_ctrl_model.sv
// System controller side of the fault pin.
// Assumes an external pull-up on the open-drain fault line.
`timescale 1ns/1ns
module ocf_ctrl_model (
	input  wire fault_pin_oe, // Sensor pulls pin low
	output wire fault_pin_i   // Resolved pin level
);
	assign fault_pin_i = fault_pin_oe ? 1'b0 : 1'b1;
	// Reader conversion of the temperature code
	function real to_celsius(input [11:0] code);
		to_celsius = (code - 2200.0) / 13.5 + 25.0;
	endfunction
endmodule

// file: bench/ocf_top_chk.sv
// Port checker for the fault supervision block.
// Bound to ocf_top; sees its ports only, one clock domain.
`timescale 1ns/1ns
module ocf_top_chk #(
	parameter BIDIR = 1,
	parameter CW    = 10
) (
	input wire        clk_sys,             // Clock
	input wire        rstn,                // Reset
	input wire [25:0] nv_trim_init,        // Trim init
	input wire [25:0] nv_fault_init,       // Fault init
	input wire [25:0] nv_scratch_init,     // Scratch init
	input wire [7:0]  meas_percent,        // Current
	input wire [11:0] temp_code,           // Temperature
	input wire        undervoltage_pin,    // Supply low
	input wire        overvoltage_pin,     // Supply high
	input wire        fault_pin_i,         // Pin readback
	input wire        prog_req,            // Request
	input wire        prog_wr,             // Write
	input wire        prog_via_output,     // Output path
	input wire [7:0]  prog_addr,           // Address
	input wire [25:0] prog_wdata,          // Write data
	input wire        prog_ack,            // Done
	input wire        prog_refused,        // Refused
	input wire [27:0] prog_rdata,          // Read data
	input wire        fault_pin_o,         // Pin level
	input wire        fault_pin_oe,        // Pin drive
	input wire        pullup_disconnect,   // Pull-up off
	input wire        output_sense_invert, // Polarity
	input wire        clamp_enable,        // Clamps
	input wire [8:0]  zero_current_offset, // Offset
	input wire [8:0]  gain_code,           // Gain
	input wire        config_ready         // Loaded
);
	localparam int QMIN = 46;
	reg [9:0] nz_cnt;
	wire      mapped = prog_addr == 8'h09 || prog_addr == 8'h0A || prog_addr == 8'h0B ||
		prog_addr == 8'h19 || prog_addr == 8'h1A || prog_addr == 8'h20;
	// Cycles the current has been non-zero
	always @(posedge clk_sys) begin
		if (!rstn || meas_percent == 8'h00)
			nz_cnt <= 10'h000;
		else if (nz_cnt != 10'h3FF)
			nz_cnt <= nz_cnt + 10'h001;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	property p_answer; prog_req |=> prog_ack != prog_refused; endproperty
	a_answer: assert property (p_answer) else $error("request not answered once");
	property p_early; prog_req && !($past(rstn) && $past(rstn, 2)) |=> prog_refused; endproperty
	a_early: assert property (p_early) else $error("early request not refused");
	property p_stat_wr; prog_req && prog_wr && prog_addr == 8'h20 |=> prog_refused; endproperty
	a_stat_wr: assert property (p_stat_wr) else $error("status write not refused");
	property p_unmap; prog_req && !mapped |=> prog_refused; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
	property p_temp;
		prog_req && !prog_wr && !prog_via_output && prog_addr == 8'h20 && config_ready
			|=> prog_ack && prog_rdata[27:16] == $past(temp_code);
	endproperty
	a_temp: assert property (p_temp) else $error("temperature field wrong");
	property p_load;
		$rose(config_ready) |-> gain_code == nv_trim_init[8:0] && zero_current_offset == nv_trim_init[17:9];
	endproperty
	a_load: assert property (p_load) else $error("trim word not loaded");
	property p_cfg_chg; $changed(gain_code) |-> $rose(config_ready) || $past(prog_ack) || $past(prog_ack, 2);
	endproperty
	a_cfg_chg: assert property (p_cfg_chg) else $error("gain changed without write");
	property p_qual; $rose(fault_pin_oe) |-> nz_cnt >= QMIN || temp_code[11:8] != 4'h0; endproperty
	a_qual: assert property (p_qual) else $error("fault before qualifier time");
	property p_drive; fault_pin_o == 1'b0; endproperty
	a_drive: assert property (p_drive) else $error("fault pin driven high");
	property p_ready; config_ready |=> config_ready; endproperty
	a_ready: assert property (p_ready) else $error("ready dropped");
	c_refuse: cover property (prog_refused);
	c_trip: cover property ($rose(fault_pin_oe));
	c_release: cover property ($fell(fault_pin_oe));
endmodule

// file: bench/overcurrent_fault_and_config_logic_bench.sv
// Self-checking bench for the fault supervision block.
// Drives ocf_top at falling edges; the controller model resolves the fault pin.
`timescale 1ns/1ns
`include "ocf_defines.vh"
module overcurrent_fault_and_config_logic_bench;
	localparam int QNS [8] = '{2300, 2900, 5000, 7600, 10100, 12600, 15300, 17900};
	localparam int HP [4] = '{11, 22, 42, 75};
	reg         clk_sys = 1'b0;
	reg         rstn = 1'b0;
	reg  [25:0] tinit, finit, sinit, d;
	reg  [7:0]  meas_percent = 8'h00;
	reg  [11:0] temp_code = 12'h0A5;
	reg         prog_req = 1'b0, prog_wr = 1'b0, prog_via_output = 1'b0;
	reg  [7:0]  prog_addr = 8'h00;
	reg  [25:0] prog_wdata = 26'h0;
	reg  [31:0] seed = 32'd84;
	reg  [29:0] ent;
	reg  [29:0] q [$];
	integer     failures = 0, n_tests = 0, cycles = 0, i, rel;
	wire        prog_ack, prog_refused, fault_pin_o, fault_pin_oe, fault_pin_i;
	wire        pullup_disconnect, output_sense_invert, clamp_enable, config_ready;
	wire [27:0] prog_rdata;
	wire [8:0]  zero_current_offset, gain_code;
	always #25 clk_sys = ~clk_sys;
	ocf_top DUT (.clk_sys(clk_sys), .rstn(rstn), .nv_trim_init(tinit), .nv_fault_init(finit),
		.nv_scratch_init(sinit), .meas_percent(meas_percent), .temp_code(temp_code),
		.undervoltage_pin(1'b0), .overvoltage_pin(1'b0), .fault_pin_i(fault_pin_i), .prog_req(prog_req),
		.prog_wr(prog_wr), .prog_via_output(prog_via_output), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
		.prog_ack(prog_ack), .prog_refused(prog_refused), .prog_rdata(prog_rdata), .fault_pin_o(fault_pin_o),
		.fault_pin_oe(fault_pin_oe), .pullup_disconnect(pullup_disconnect),
		.output_sense_invert(output_sense_invert), .clamp_enable(clamp_enable),
		.zero_current_offset(zero_current_offset), .gain_code(gain_code), .config_ready(config_ready));
	ocf_ctrl_model u_ctrl (.fault_pin_oe(fault_pin_oe), .fault_pin_i(fault_pin_i));
	function [31:0] xs(input [31:0] v);
		reg [31:0] x;
		begin
			x = v ^ (v << 13);
			x = x ^ (x >> 17);
			xs = x ^ (x << 5);
		end
	endfunction
	function [25:0] fw(input [1:0] h, input hold, input pd, input nd, input [2:0] ql, input [3:0] ot);
		fw = {h, hold, pd, nd, ql, ot, 7'd50, 7'd50};
	endfunction
	task cmp(input [63:0] what, input [27:0] e, input [27:0] g);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				failures = failures + 1;
				$display("MISMATCH %0s expected %h seen %h", what, e, g);
			end
		end
	endtask
	task acc(input wr, input via, input [7:0] a, input [25:0] dat, input chk, input refd);
		begin
			q.push_back({chk, refd, 2'b00, dat});
			@(negedge clk_sys);
			prog_req = 1'b1;
			prog_wr = wr;
			prog_via_output = via;
			prog_addr = a;
			prog_wdata = wr ? dat : 26'h0;
			@(negedge clk_sys);
			prog_req = 1'b0;
		end
	endtask
	task pin(input e, input integer n);
		begin
			repeat (n) @(negedge clk_sys);
			cmp("fault", {27'h0, e}, {27'h0, fault_pin_oe});
		end
	endtask
	task start;
		begin
			repeat (4) @(negedge clk_sys);
			rstn = 1'b1;
			acc(1'b0, 1'b0, 8'h19, 26'h0, 1'b0, 1'b1);
			i = 0;
			while (config_ready !== 1'b1 && i < 20) begin
				@(negedge clk_sys);
				i = i + 1;
			end
		end
	endtask
	task done(input integer n);
		$display("test %0d done", n);
	endtask
	task final_report;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, failures);
			if (failures == 0 && n_tests > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// Answers are matched in order of request
	always @(negedge clk_sys) begin
		if (rstn && (prog_ack === 1'b1 || prog_refused === 1'b1)) begin
			ent = q.pop_front();
			cmp("refused", {27'h0, ent[28]}, {27'h0, prog_refused});
			if (ent[29])
				cmp("rdata", ent[27:0], prog_rdata);
		end
	end
	always @(posedge clk_sys) begin
		cycles = cycles + 1;
		if (cycles == 12000) begin
			failures = failures + 1;
			final_report;
		end
	end
	initial begin
		seed = xs(seed);
		tinit = {8'h00, seed[17:0]};
		finit = fw(2'd0, 1'b0, 1'b0, 1'b0, 3'd0, 4'hF);
		seed = xs(seed);
		sinit = seed[25:0];
		repeat (12) @(negedge clk_sys);
		start;
		acc(1'b0, 1'b0, 8'h19, tinit, 1'b1, 1'b0);
		acc(1'b0, 1'b0, 8'h1A, finit, 1'b1, 1'b0);
		acc(1'b0, 1'b0, 8'h0B, sinit, 1'b1, 1'b0);
		cmp("gain", {19'h0, tinit[8:0]}, {19'h0, gain_code});
		cmp("offset", {19'h0, tinit[17:9]}, {19'h0, zero_current_offset});
		acc(1'b1, 1'b0, 8'h19, tinit | 26'h0340000, 1'b0, 1'b0);
		pin(1'b0, 3);
		cmp("trimbits", 28'h7, {25'h0, output_sense_invert, clamp_enable, pullup_disconnect});
		acc(1'b1, 1'b0, 8'h19, tinit, 1'b0, 1'b0);
		for (i = 0; i < 3; i = i + 1) begin
			seed = xs(seed);
			d = seed[25:0];
			acc(1'b1, 1'b0, 8'h0B, d, 1'b0, 1'b0);
			acc(1'b0, 1'b0, 8'h0B, d, 1'b1, 1'b0);
		end
		done(1);
		for (i = 0; i < 8; i = i + 1) begin
			acc(1'b1, 1'b0, 8'h1A, fw(2'd0, 1'b0, 1'b0, 1'b0, i[2:0], 4'hF), 1'b0, 1'b0);
			meas_percent = 8'd60;
			pin(1'b0, (QNS[i] + 49) / 50 - 2);
			pin(1'b1, 4);
			meas_percent = 8'd0;
			pin(1'b0, 30);
		end
		meas_percent = 8'd60;
		pin(1'b0, 30);
		meas_percent = 8'd0;
		pin(1'b0, 60);
		done(2);
		for (i = 0; i < 4; i = i + 1) begin
			acc(1'b1, 1'b0, 8'h1A, fw(i[1:0], 1'b0, 1'b0, 1'b0, 3'd0, 4'hF), 1'b0, 1'b0);
			rel = 50 - (HP[i] < 25 ? HP[i] : 25);
			meas_percent = 8'd60;
			pin(1'b1, 60);
			meas_percent = rel[7:0];
			pin(1'b1, 40);
			meas_percent = rel[7:0] - 8'd1;
			pin(1'b0, 30);
		end
		meas_percent = 8'hC4;
		pin(1'b1, 60);
		acc(1'b0, 1'b0, 8'h20, 26'h0A50505, 1'b1, 1'b0);
		meas_percent = 8'd0;
		pin(1'b0, 30);
		acc(1'b1, 1'b0, 8'h1A, fw(2'd0, 1'b0, 1'b0, 1'b1, 3'd0, 4'hF), 1'b0, 1'b0);
		meas_percent = 8'hC4;
		pin(1'b0, 80);
		acc(1'b1, 1'b0, 8'h1A, fw(2'd0, 1'b1, 1'b1, 1'b0, 3'd0, 4'hF), 1'b0, 1'b0);
		acc(1'b1, 1'b0, 8'h19, tinit | 26'h0080000, 1'b0, 1'b0);
		meas_percent = 8'd60;
		pin(1'b0, 80);
		meas_percent = 8'hC4;
		pin(1'b0, 80);
		meas_percent = 8'd0;
		pin(1'b0, 30);
		acc(1'b1, 1'b0, 8'h19, tinit, 1'b0, 1'b0);
		done(3);
		acc(1'b1, 1'b0, 8'h1A, fw(2'd0, 1'b1, 1'b0, 1'b0, 3'd0, 4'h7), 1'b0, 1'b0);
		temp_code = 12'h898;
		pin(1'b1, 5);
		temp_code = 12'h0A5;
		acc(1'b1, 1'b0, 8'h1A, fw(2'd0, 1'b1, 1'b0, 1'b0, 3'd0, 4'hF), 1'b0, 1'b0);
		pin(1'b1, 50);
		rstn = 1'b0;
		start;
		pin(1'b0, 1);
		acc(1'b0, 1'b0, 8'h1A, finit, 1'b1, 1'b0);
		done(4);
		acc(1'b1, 1'b0, 8'h09, tinit, 1'b0, 1'b0);
		acc(1'b0, 1'b0, 8'h09, tinit, 1'b1, 1'b0);
		acc(1'b1, 1'b0, 8'h19, tinit | 26'h2000000, 1'b0, 1'b0);
		acc(1'b1, 1'b0, 8'h09, 26'h0, 1'b0, 1'b1);
		acc(1'b1, 1'b0, 8'h0B, 26'h0, 1'b0, 1'b1);
		acc(1'b1, 1'b0, 8'h19, tinit | 26'h1000000, 1'b0, 1'b0);
		acc(1'b0, 1'b1, 8'h19, 26'h0, 1'b0, 1'b1);
		acc(1'b0, 1'b0, 8'h19, tinit | 26'h1000000, 1'b1, 1'b0);
		acc(1'b1, 1'b0, 8'h19, tinit, 1'b0, 1'b0);
		acc(1'b0, 1'b0, 8'h33, 26'h0, 1'b0, 1'b1);
		acc(1'b1, 1'b0, 8'h20, 26'h0, 1'b0, 1'b1);
		acc(1'b0, 1'b0, 8'h20, 26'h0, 1'b0, 1'b0);
		q.push_back({2'b10, 12'h0A5, 16'h0000});
		acc(1'b0, 1'b0, 8'h20, 26'h0, 1'b0, 1'b0);
		void'(q.pop_back());
		pin(1'b0, 3);
		cmp("queue", 28'h0, 28'(q.size()));
		done(5);
		final_report;
	end
endmodule

bind ocf_top ocf_top_chk #(.BIDIR(BIDIR), .CW(CW)) u_chk (.clk_sys(clk_sys), .rstn(rstn),
	.nv_trim_init(nv_trim_init), .nv_fault_init(nv_fault_init), .nv_scratch_init(nv_scratch_init),
	.meas_percent(meas_percent), .temp_code(temp_code), .undervoltage_pin(undervoltage_pin),
	.overvoltage_pin(overvoltage_pin), .fault_pin_i(fault_pin_i), .prog_req(prog_req), .prog_wr(prog_wr),
	.prog_via_output(prog_via_output), .prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_ack(prog_ack),
	.prog_refused(prog_refused), .prog_rdata(prog_rdata), .fault_pin_o(fault_pin_o),
	.fault_pin_oe(fault_pin_oe), .pullup_disconnect(pullup_disconnect),
	.output_sense_invert(output_sense_invert), .clamp_enable(clamp_enable),
	.zero_current_offset(zero_current_offset), .gain_code(gain_code), .config_ready(config_ready));

// file: logic/ocf_defines.vh
// Constants of the overcurrent fault and configuration block.
// Included by the top module and the bench; definitions only.
`ifndef OCF_DEFINES_VH
`define OCF_DEFINES_VH

`define OCF_CLK_NS        50
// Register offsets
`define OCF_ADDR_NV_TRIM    8'h09
`define OCF_ADDR_NV_FAULT   8'h0A
`define OCF_ADDR_NV_SCRATCH 8'h0B
`define OCF_ADDR_LIVE_TRIM  8'h19
`define OCF_ADDR_LIVE_FAULT 8'h1A
`define OCF_ADDR_STATUS     8'h20
`define OCF_WORD_W          26
`define OCF_STAT_W          28
// Trim word fields
`define OCF_T_WLOCK       25
`define OCF_T_LINKLOCK    24
`define OCF_T_OTDIS       22
`define OCF_T_INVERT      21
`define OCF_T_CLAMP       20
`define OCF_T_FMASK       19
`define OCF_T_PULLUP      18
`define OCF_T_OFFS_HI     17
`define OCF_T_OFFS_LO     9
`define OCF_T_GAIN_HI     8
`define OCF_T_GAIN_LO     0
// Fault word fields
`define OCF_F_HYST_HI     25
`define OCF_F_HYST_LO     24
`define OCF_F_HOLD        23
`define OCF_F_PDIS        22
`define OCF_F_NDIS        21
`define OCF_F_QUAL_HI     20
`define OCF_F_QUAL_LO     18
`define OCF_F_OTLIM_HI    17
`define OCF_F_OTLIM_LO    14
`define OCF_F_NTHR_HI     13
`define OCF_F_NTHR_LO     7
`define OCF_F_PTHR_HI     6
`define OCF_F_PTHR_LO     0
// Status word fields
`define OCF_S_TEMP_HI     27
`define OCF_S_TEMP_LO     16
`define OCF_S_UV_NOW      12
`define OCF_S_OV_NOW      11
`define OCF_S_OC_NOW      10
`define OCF_S_OT_NOW      9
`define OCF_S_FP_NOW      8
`define OCF_S_UV_SEEN     4
`define OCF_S_OV_SEEN     3
`define OCF_S_OC_SEEN     2
`define OCF_S_OT_SEEN     1
`define OCF_S_FP_SEEN     0
// Qualifier delays in ns
`define OCF_QUAL0_NS      2300
`define OCF_QUAL1_NS      2900
`define OCF_QUAL2_NS      5000
`define OCF_QUAL3_NS      7600
`define OCF_QUAL4_NS      10100
`define OCF_QUAL5_NS      12600
`define OCF_QUAL6_NS      15300
`define OCF_QUAL7_NS      17900
// Fault clear time in ns
`define OCF_CLEAR_NS      1000
// Hysteresis in percent
`define OCF_HYST0_PCT     8'h0B
`define OCF_HYST1_PCT     8'h16
`define OCF_HYST2_PCT     8'h2A
`define OCF_HYST3_PCT     8'h4B
`define OVERCURRENT_RELEASE_MARGIN_FLOOR    8'h19
// Reset values
`define OCF_WORD_RST      26'h0000000
`define OCF_STAT_RST      28'h0000000

`endif

// file: logic/ocf_sync.v
// Three-stage synchroniser for pin inputs, one per bit.
// Output follows once the second and third stages agree.
`timescale 1ns/1ns
module ocf_sync #(
	parameter W = 1
) (
	input  wire         clk_sys, // System clock
	input  wire         rstn,    // Synchronous reset, active low
	input  wire [W-1:0] pin,     // Asynchronous inputs
	output reg  [W-1:0] level    // Filtered synchronous level
);
	reg [W-1:0] stage1;
	reg [W-1:0] stage2;
	reg [W-1:0] stage3;
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge clk_sys) begin
				if (!rstn) begin
					stage1[i] <= 1'b0;
					stage2[i] <= 1'b0;
					stage3[i] <= 1'b0;
					level[i]  <= 1'b0;
				end else begin
					stage1[i] <= pin[i];
					stage2[i] <= stage1[i];
					stage3[i] <= stage2[i];
					if (stage2[i] == stage3[i]) begin
						level[i] <= stage3[i];
					end
				end
			end
		end
	endgenerate
endmodule

// file: logic/ocf_top.v
// Fault supervision and configuration words of the current sensor.
// Expects a same-clock signed current sample in percent, a same-clock temperature code,
// a decoded programming request port and asynchronous supply comparator and fault pin levels.
`timescale 1ns/1ns
`include "ocf_defines.vh"
module ocf_top #(
	parameter BIDIR = 1,
	parameter CW    = 10
) (
	input  wire        clk_sys,           // System clock, 20 MHz
	input  wire        rstn,              // Synchronous reset, active low
	input  wire [25:0] nv_trim_init,      // Stored trim word from array
	input  wire [25:0] nv_fault_init,     // Stored fault word from array
	input  wire [25:0] nv_scratch_init,   // Stored scratch word from array
	input  wire [7:0]  meas_percent,      // Signed current sample, percent
	input  wire [11:0] temp_code,         // Die temperature code
	input  wire        undervoltage_pin,  // Supply low comparator
	input  wire        overvoltage_pin,   // Supply high comparator
	input  wire        fault_pin_i,       // Fault pin level read back
	input  wire        prog_req,          // Access request pulse
	input  wire        prog_wr,           // Request is a write
	input  wire        prog_via_output,   // Request came over output pin
	input  wire [7:0]  prog_addr,         // Word address
	input  wire [25:0] prog_wdata,        // Write data
	output reg         prog_ack,          // Access done pulse
	output reg         prog_refused,      // Access refused pulse
	output reg  [27:0] prog_rdata,        // Read data
	output reg         fault_pin_o,       // Fault pin drive level
	output reg         fault_pin_oe,      // Fault pin pulled low when high
	output reg         pullup_disconnect, // Fault pull-up removed
	output reg         output_sense_invert, // Output polarity
	output reg         clamp_enable,      // Output clamps on
	output reg  [8:0]  zero_current_offset, // Offset code
	output reg  [8:0]  gain_code,         // Gain code
	output reg         config_ready       // Shadow words loaded
);
	localparam ST_CAPTURE = 2'b00;
	localparam ST_LOAD    = 2'b01;
	localparam ST_RUN     = 2'b10;

	reg [1:0]  state;
	reg [25:0] nv_trim_word;
	reg [25:0] nv_fault_word;
	reg [25:0] nv_scratch_word;
	reg [25:0] live_trim_word;
	reg [25:0] live_fault_word;
	reg        undervoltage_seen;
	reg        overvoltage_seen;
	reg        overcurrent_seen;
	reg        overtemp_seen;
	reg        fault_pin_seen;
	reg        fault_held;
	reg        fault_pin_prev;

	wire [2:0] pin_level;
	wire       undervoltage_now = pin_level[0];
	wire       overvoltage_now  = pin_level[1];
	wire       fault_pin_now    = pin_level[2]; // Inverted before sync, idle reads 0

	function [CW-1:0] ns_to_cycles;
		input integer ns;
		integer c;
		begin
			c = (ns + `OCF_CLK_NS - 1) / `OCF_CLK_NS;
			if (c < 1) begin
				c = 1;
			end
			ns_to_cycles = c[CW-1:0];
		end
	endfunction

	function [CW-1:0] qual_lookup;
		input [2:0] code;
		begin
			case (code)
				3'h0: qual_lookup = ns_to_cycles(`OCF_QUAL0_NS);
				3'h1: qual_lookup = ns_to_cycles(`OCF_QUAL1_NS);
				3'h2: qual_lookup = ns_to_cycles(`OCF_QUAL2_NS);
				3'h3: qual_lookup = ns_to_cycles(`OCF_QUAL3_NS);
				3'h4: qual_lookup = ns_to_cycles(`OCF_QUAL4_NS);
				3'h5: qual_lookup = ns_to_cycles(`OCF_QUAL5_NS);
				3'h6: qual_lookup = ns_to_cycles(`OCF_QUAL6_NS);
				default: qual_lookup = ns_to_cycles(`OCF_QUAL7_NS);
			endcase
		end
	endfunction

	// Release level of one trip point, hysteresis capped by threshold minus floor
	function [7:0] release_of;
		input [6:0] thr;
		input [1:0] code;
		reg [7:0] hyst;
		reg [7:0] cap;
		reg [7:0] t8;
		begin
			t8 = {1'b0, thr};
			case (code)
				2'h0: hyst = `OCF_HYST0_PCT;
				2'h1: hyst = `OCF_HYST1_PCT;
				2'h2: hyst = `OCF_HYST2_PCT;
				default: hyst = `OCF_HYST3_PCT;
			endcase
			cap = (t8 > `OVERCURRENT_RELEASE_MARGIN_FLOOR) ? (t8 - `OVERCURRENT_RELEASE_MARGIN_FLOOR) : 8'h00;
			if (hyst > cap) begin
				hyst = cap;
			end
			release_of = t8 - hyst;
		end
	endfunction

	// Shadow fields govern behaviour once loaded
	wire       write_lock           = live_trim_word[`OCF_T_WLOCK];
	wire       output_link_protect  = live_trim_word[`OCF_T_LINKLOCK];
	wire       overtemp_disable     = live_trim_word[`OCF_T_OTDIS];
	wire       fault_pin_mask       = live_trim_word[`OCF_T_FMASK];
	wire [1:0] overcurrent_release_margin = live_fault_word[`OCF_F_HYST_HI:`OCF_F_HYST_LO];
	wire       fault_hold           = live_fault_word[`OCF_F_HOLD];
	wire       pos_overcurrent_disable = live_fault_word[`OCF_F_PDIS];
	wire       neg_overcurrent_disable = live_fault_word[`OCF_F_NDIS];
	wire [2:0] overcurrent_qualify_delay = live_fault_word[`OCF_F_QUAL_HI:`OCF_F_QUAL_LO];
	wire [3:0] overtemp_limit       = live_fault_word[`OCF_F_OTLIM_HI:`OCF_F_OTLIM_LO];
	wire [6:0] neg_overcurrent_threshold = live_fault_word[`OCF_F_NTHR_HI:`OCF_F_NTHR_LO];
	wire [6:0] pos_overcurrent_threshold = live_fault_word[`OCF_F_PTHR_HI:`OCF_F_PTHR_LO];

	wire          running   = (state == ST_RUN);
	wire [7:0]    pos_level = meas_percent[7] ? 8'h00 : meas_percent;
	wire [7:0]    neg_level = meas_percent[7] ? (8'h00 - meas_percent) : 8'h00;
	wire [CW-1:0] qual_cycles  = qual_lookup(overcurrent_qualify_delay);
	wire [CW-1:0] clear_cycles = ns_to_cycles(`OCF_CLEAR_NS);
	wire          pos_trip;
	wire          neg_trip;
	wire          neg_enable = (BIDIR != 0) && running && !neg_overcurrent_disable;
	wire          pos_enable = running && !pos_overcurrent_disable;
	wire          overcurrent_now = pos_trip | neg_trip;
	wire          overtemp_now    = running && !overtemp_disable && (temp_code[11:8] > overtemp_limit);
	wire          fault_cond      = overcurrent_now | overtemp_now;
	wire          next_fault_held = fault_held | (fault_hold & fault_cond & !fault_pin_mask);
	wire          next_fault_drive = !fault_pin_mask && (fault_cond || next_fault_held);

	wire [27:0] status_word;
	assign status_word = {temp_code, 3'h0, undervoltage_now, overvoltage_now, overcurrent_now, overtemp_now,
		fault_pin_now, 3'h0, undervoltage_seen, overvoltage_seen, overcurrent_seen, overtemp_seen,
		fault_pin_seen};

	ocf_sync #(
		.W (3)
	) u_sync (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.pin     ({~fault_pin_i, overvoltage_pin, undervoltage_pin}),
		.level   (pin_level)
	);

	ocf_trip #(
		.LW (8),
		.CW (CW)
	) u_pos_trip (
		.clk_sys      (clk_sys),
		.rstn         (rstn),
		.enable       (pos_enable),
		.level        (pos_level),
		.thresh       ({1'b0, pos_overcurrent_threshold}),
		.release_lvl  (release_of(pos_overcurrent_threshold, overcurrent_release_margin)),
		.qual_cycles  (qual_cycles),
		.clear_cycles (clear_cycles),
		.tripped      (pos_trip)
	);

	ocf_trip #(
		.LW (8),
		.CW (CW)
	) u_neg_trip (
		.clk_sys      (clk_sys),
		.rstn         (rstn),
		.enable       (neg_enable),
		.level        (neg_level),
		.thresh       ({1'b0, neg_overcurrent_threshold}),
		.release_lvl  (release_of(neg_overcurrent_threshold, overcurrent_release_margin)),
		.qual_cycles  (qual_cycles),
		.clear_cycles (clear_cycles),
		.tripped      (neg_trip)
	);

	wire link_ok    = !(prog_via_output && output_link_protect);
	wire access_ok  = prog_req && running && link_ok;
	wire nv_addr    = (prog_addr == `OCF_ADDR_NV_TRIM) || (prog_addr == `OCF_ADDR_NV_FAULT) ||
		(prog_addr == `OCF_ADDR_NV_SCRATCH);
	wire live_addr  = (prog_addr == `OCF_ADDR_LIVE_TRIM) || (prog_addr == `OCF_ADDR_LIVE_FAULT);
	wire read_ok    = nv_addr || live_addr || (prog_addr == `OCF_ADDR_STATUS);
	wire write_ok   = (nv_addr && !write_lock) || live_addr;
	wire do_write   = access_ok && prog_wr && write_ok;
	wire do_read    = access_ok && !prog_wr && read_ok;
	wire status_rd  = do_read && (prog_addr == `OCF_ADDR_STATUS);

	// Startup sequence and stored words
	always @(posedge clk_sys) begin
		if (!rstn) begin
			state           <= ST_CAPTURE;
			nv_trim_word    <= `OCF_WORD_RST;
			nv_fault_word   <= `OCF_WORD_RST;
			nv_scratch_word <= `OCF_WORD_RST;
			live_trim_word  <= `OCF_WORD_RST;
			live_fault_word <= `OCF_WORD_RST;
		end else begin
			case (state)
				ST_CAPTURE: begin
					nv_trim_word    <= nv_trim_init;
					nv_fault_word   <= nv_fault_init;
					nv_scratch_word <= nv_scratch_init;
					state           <= ST_LOAD;
				end
				ST_LOAD: begin
					live_trim_word  <= nv_trim_word;
					live_fault_word <= nv_fault_word;
					state           <= ST_RUN;
				end
				ST_RUN: begin
					if (do_write) begin
						case (prog_addr)
							`OCF_ADDR_NV_TRIM:    nv_trim_word    <= prog_wdata;
							`OCF_ADDR_NV_FAULT:   nv_fault_word   <= prog_wdata;
							`OCF_ADDR_NV_SCRATCH: nv_scratch_word <= prog_wdata;
							`OCF_ADDR_LIVE_TRIM:  live_trim_word  <= prog_wdata;
							default:              live_fault_word <= prog_wdata;
						endcase
					end
				end
				default: begin
					state <= ST_CAPTURE;
				end
			endcase
		end
	end

	// Programming answers, one cycle after the request
	always @(posedge clk_sys) begin
		if (!rstn) begin
			prog_ack     <= 1'b0;
			prog_refused <= 1'b0;
			prog_rdata   <= `OCF_STAT_RST;
		end else begin
			prog_ack     <= do_write || do_read;
			prog_refused <= prog_req && !(do_write || do_read);
			if (do_read) begin
				case (prog_addr)
					`OCF_ADDR_NV_TRIM:    prog_rdata <= {2'b00, nv_trim_word};
					`OCF_ADDR_NV_FAULT:   prog_rdata <= {2'b00, nv_fault_word};
					`OCF_ADDR_NV_SCRATCH: prog_rdata <= {2'b00, nv_scratch_word};
					`OCF_ADDR_LIVE_TRIM:  prog_rdata <= {2'b00, live_trim_word};
					`OCF_ADDR_LIVE_FAULT: prog_rdata <= {2'b00, live_fault_word};
					default:              prog_rdata <= status_word;
				endcase
			end
		end
	end

	// Sticky events, cleared by a status read; a new event wins over the clear
	always @(posedge clk_sys) begin
		if (!rstn) begin
			undervoltage_seen <= 1'b0;
			overvoltage_seen  <= 1'b0;
			overcurrent_seen  <= 1'b0;
			overtemp_seen     <= 1'b0;
			fault_pin_seen    <= 1'b0;
			fault_pin_prev    <= 1'b0;
		end else begin
			fault_pin_prev    <= fault_pin_now;
			undervoltage_seen <= undervoltage_now | (undervoltage_seen & !status_rd);
			overvoltage_seen  <= overvoltage_now | (overvoltage_seen & !status_rd);
			overcurrent_seen  <= overcurrent_now | (overcurrent_seen & !status_rd);
			overtemp_seen     <= overtemp_now | (overtemp_seen & !status_rd);
			fault_pin_seen    <= (fault_pin_now & !fault_pin_prev) | (fault_pin_seen & !status_rd);
		end
	end

	// Fault pin and configuration outputs
	always @(posedge clk_sys) begin
		if (!rstn) begin
			fault_held          <= 1'b0;
			fault_pin_o         <= 1'b0;
			fault_pin_oe        <= 1'b0;
			pullup_disconnect   <= 1'b0;
			output_sense_invert <= 1'b0;
			clamp_enable        <= 1'b0;
			zero_current_offset <= 9'h000;
			gain_code           <= 9'h000;
			config_ready        <= 1'b0;
		end else begin
			fault_held          <= next_fault_held;
			fault_pin_o         <= 1'b0;
			fault_pin_oe        <= next_fault_drive;
			pullup_disconnect   <= live_trim_word[`OCF_T_PULLUP];
			output_sense_invert <= live_trim_word[`OCF_T_INVERT];
			clamp_enable        <= live_trim_word[`OCF_T_CLAMP];
			zero_current_offset <= live_trim_word[`OCF_T_OFFS_HI:`OCF_T_OFFS_LO];
			gain_code           <= live_trim_word[`OCF_T_GAIN_HI:`OCF_T_GAIN_LO];
			config_ready        <= running;
		end
	end
endmodule

// file: logic/ocf_trip.v
// One overcurrent trip point: qualify on the way in, clear timer on the way out.
// Level and thresholds come from logic on the same clock.
`timescale 1ns/1ns
module ocf_trip #(
	parameter LW = 8,
	parameter CW = 10
) (
	input  wire          clk_sys,      // System clock
	input  wire          rstn,         // Synchronous reset, active low
	input  wire          enable,       // Trip point in use
	input  wire [LW-1:0] level,        // Current magnitude
	input  wire [LW-1:0] thresh,       // Trip level
	input  wire [LW-1:0] release_lvl,  // Release level
	input  wire [CW-1:0] qual_cycles,  // Cycles above trip level needed
	input  wire [CW-1:0] clear_cycles, // Cycles below release level needed
	output reg           tripped       // Condition qualified
);
	reg  [CW-1:0] count;
	wire [CW-1:0] count_inc = count + {{(CW-1){1'b0}}, 1'b1};

	always @(posedge clk_sys) begin
		if (!rstn || !enable) begin
			tripped <= 1'b0;
			count   <= {CW{1'b0}};
		end else if (!tripped) begin
			if (level > thresh) begin
				if (count_inc >= qual_cycles) begin
					tripped <= 1'b1;
					count   <= {CW{1'b0}};
				end else begin
					count <= count_inc;
				end
			end else begin
				count <= {CW{1'b0}};
			end
		end else begin
			if (level < release_lvl) begin
				if (count_inc >= clear_cycles) begin
					tripped <= 1'b0;
					count   <= {CW{1'b0}};
				end else begin
					count <= count_inc;
				end
			end else begin
				count <= {CW{1'b0}};
			end
		end
	end
endmodule
